// >>> core/pbcs_pkg.sv
// shared types and constants of the bus-master command selector
package pbcs_pkg;
   // bus command codes
   localparam logic [3:0] PBCS_CMD_MR = 4'h6;
   localparam logic [3:0] PBCS_CMD_MW = 4'h7;
   localparam logic [3:0] PBCS_CMD_MRM = 4'hc;
   localparam logic [3:0] PBCS_CMD_MRL = 4'he;
   localparam logic [3:0] PBCS_CMD_MWI = 4'hf;
   // cache line sizes, in dwords, that allow line commands
   localparam logic [7:0] PBCS_CLS_8 = 8'h08;
   localparam logic [7:0] PBCS_CLS_16 = 8'h10;
   localparam logic [4:0] PBCS_LINE_8 = 5'h08;
   localparam logic [4:0] PBCS_LINE_16 = 5'h10;
   localparam logic [3:0] PBCS_MASK_8 = 4'h7;
   localparam logic [3:0] PBCS_MASK_16 = 4'hf;
   // byte enables and reset values
   localparam logic [3:0] PBCS_BE_ALL = 4'hf;
   localparam logic [15:0] PBCS_LEN_RST = 16'h0000;
   localparam logic [61:0] PBCS_ADDR_RST = 62'h0;
   localparam logic [1:0] PBCS_LINEAR_ORDER = 2'h0;

   // sequencer states, gray along idle-plan-issue-data
   typedef enum logic [1:0]
   {
      PBCS_IDLE = 2'b00,
      PBCS_PLAN = 2'b01,
      PBCS_ISSUE = 2'b11,
      PBCS_DATA = 2'b10
   } pbcs_state_t;

   // one DMA move asked for by the rx or tx engine
   typedef struct packed
   {
      logic write;
      logic [61:0] addr_dw;
      logic [15:0] len_dw;
      logic [3:0] last_be;
   } pbcs_req_t;

   // one bus transaction handed to the bus engine
   typedef struct packed
   {
      logic [3:0] cmd;
      logic dac;
      logic [63:0] addr;
      logic [15:0] len_dw;
   } pbcs_txn_t;
endpackage : pbcs_pkg

// >>> core/pbcs_line_calc.sv
// cache-line geometry of the current dword address
`timescale 1ns/10ps
`default_nettype none
module pbcs_line_calc
   import pbcs_pkg::*;
(
   // inputs
   input wire logic [3:0] addr_lo,
   input wire logic [7:0] cls,
   input wire logic [15:0] rem,
   // geometry
   output logic line_ok,
   output logic [4:0] line_dw,
   output logic aligned,
   output logic [4:0] to_bnd,
   output logic [15:0] full_dw,
   output logic at_end
);
   logic line16;
   logic [3:0] mask;
   logic [3:0] off;

   // offset inside the line and distance to its end
   always_comb
   begin
      line16 = (cls == PBCS_CLS_16);
      line_ok = line16 || (cls == PBCS_CLS_8);
      mask = line16 ? PBCS_MASK_16 : PBCS_MASK_8;
      line_dw = line16 ? PBCS_LINE_16 : PBCS_LINE_8;
      off = addr_lo & mask;
      aligned = (off == 4'h0);
      to_bnd = line_dw - {1'b0, off};
      full_dw = rem & {12'hfff, ~mask}; // whole lines left
      at_end = (off == mask);            // this dword closes the line
   end
endmodule : pbcs_line_calc
`default_nettype wire

// >>> core/pbcs_top.sv
// bus-master command selection for tx fetches and rx stores
`timescale 1ns/10ps
`default_nettype none
// How it works
// (RL1) a tx read of whole cache lines goes out as memory read multiple.
// (RL2) an unaligned tx read first uses read line up to the boundary, then read multiple.
// (RL3) a read part that never reaches a line boundary uses plain memory read.
// (RL4) when the tx fifo is nearly full a read multiple burst stops at a line boundary.
// (RL5) rx writes whole lines with write-and-invalidate and partial lines with plain write.
// (RL6) write-and-invalidate needs a cache line size of 8 or 16 dwords.
// (RL7) write-and-invalidate needs a line-aligned target address.
// (RL8) write-and-invalidate needs at least one full line of data in the rx fifo.
// (RL9) write-and-invalidate needs the invalidate-enable command bit set.
// (RL10) if any of those fails the rx store uses plain memory write.
// (RL11) if a condition fails mid-burst the current line is finished and the burst ends.
// (RL12) every data phase of write-and-invalidate has all byte enables on.
// (RL13) write-and-invalidate crosses a boundary only when the whole next line follows.
// (RL14) write-and-invalidate uses linear burst ordering only.
// (RL15) buffers above 4 GB are reached with a dual address cycle.
// (RL16) the memory target should keep prefetching while a read multiple frame lasts.
// (RL17) the command of each transaction is chosen as it starts, from address, count and setup.
module pbcs_top
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // move requests
   input wire logic REQ_VALID,
   input wire pbcs_pkg::pbcs_req_t REQ,
   output logic REQ_READY,
   output logic XFER_DONE,
   // configuration space state
   input wire logic [7:0] CACHE_LINE_SIZE,
   input wire logic MWI_ENABLE,
   // fifo state
   input wire logic TX_FIFO_NEAR_FULL,
   input wire logic [7:0] RX_FIFO_DW,
   // transaction hand-off
   output logic TXN_VALID,
   output pbcs_pkg::pbcs_txn_t TXN,
   input wire logic TXN_READY,
   // data phases
   input wire logic DPHASE_DONE,
   output logic DPHASE_LAST,
   output logic [3:0] BYTE_EN,
   output logic [1:0] BURST_ORDER
);
   import pbcs_pkg::*;

   pbcs_state_t state_reg, state_next;
   logic write_reg, write_next;
   logic [61:0] addr_reg, addr_next;
   logic [15:0] rem_reg, rem_next;
   logic [15:0] tleft_reg, tleft_next;
   logic [3:0] last_be_reg, last_be_next;
   logic [3:0] be_reg, be_next;
   logic done_reg, done_next;
   pbcs_txn_t txn_reg, txn_next;
   logic line_ok, aligned, at_end, mwi_ok, mwi_hold, early_end;
   logic [4:0] line_dw, to_bnd;
   logic [15:0] full_dw, bnd_len, mwi_len;
   logic [7:0] line_lvl;

   // line geometry of the dword about to move
   pbcs_line_calc u_line
   (
      .addr_lo(addr_reg[3:0]),
      .cls(CACHE_LINE_SIZE),
      .rem(rem_reg),
      .line_ok(line_ok),
      .line_dw(line_dw),
      .aligned(aligned),
      .to_bnd(to_bnd),
      .full_dw(full_dw),
      .at_end(at_end)
   );

   // invalidate conditions, at start and for going on
   always_comb
   begin
      line_lvl = {3'h0, line_dw};
      bnd_len = {11'h000, to_bnd};
      // a final line with partial lanes is left to plain write
      mwi_len = full_dw;
      if ((full_dw == rem_reg) && (full_dw != 16'h0000) && (last_be_reg != PBCS_BE_ALL))
      begin
         mwi_len = full_dw - {11'h000, line_dw}; // see RL5
      end
      mwi_ok = line_ok && MWI_ENABLE && aligned && (mwi_len != 16'h0000) // see RL6 see RL7 see RL9
         && (RX_FIFO_DW >= line_lvl);                                  // see RL8
      mwi_hold = line_ok && MWI_ENABLE && (RX_FIFO_DW > line_lvl);     // see RL13
      early_end = at_end && (((txn_reg.cmd == PBCS_CMD_MRM) && TX_FIFO_NEAR_FULL) // see RL4
         || ((txn_reg.cmd == PBCS_CMD_MWI) && !mwi_hold));                       // see RL11
   end

   // handshake outputs
   always_comb
   begin
      REQ_READY = (state_reg == PBCS_IDLE);
      TXN_VALID = (state_reg == PBCS_ISSUE);
      DPHASE_LAST = (state_reg == PBCS_DATA) && ((tleft_reg == 16'h0001) || early_end);
   end

   // sequencer next values
   always_comb
   begin
      state_next = state_reg;
      write_next = write_reg;
      addr_next = addr_reg;
      rem_next = rem_reg;
      tleft_next = tleft_reg;
      last_be_next = last_be_reg;
      be_next = be_reg;
      done_next = 1'b0;
      txn_next = txn_reg;
      case (state_reg)
         PBCS_IDLE:
         begin
            if (REQ_VALID)
            begin
               write_next = REQ.write;
               addr_next = REQ.addr_dw;
               rem_next = REQ.len_dw;
               last_be_next = REQ.last_be;
               if (REQ.len_dw == PBCS_LEN_RST)
               begin
                  done_next = 1'b1;
               end
               else
               begin
                  state_next = PBCS_PLAN;
               end
            end
         end
         PBCS_PLAN:
         begin
            // pick command and length for this transaction
            txn_next.addr = {addr_reg, PBCS_LINEAR_ORDER};    // see RL14
            txn_next.dac = (addr_reg[61:30] != 32'h0);      // see RL15
            txn_next.len_dw = rem_reg;
            if (!write_reg)
            begin
               if (!line_ok)
               begin
                  txn_next.cmd = PBCS_CMD_MR;
               end
               else if (!aligned && (rem_reg >= bnd_len))
               begin
                  txn_next.cmd = PBCS_CMD_MRL;              // see RL2
                  txn_next.len_dw = bnd_len;
               end
               else if (aligned && (full_dw != 16'h0000))
               begin
                  txn_next.cmd = PBCS_CMD_MRM;              // see RL1 see RL17
                  txn_next.len_dw = full_dw;
               end
               else
               begin
                  txn_next.cmd = PBCS_CMD_MR;               // see RL3
               end
            end
            else if (mwi_ok)
            begin
               txn_next.cmd = PBCS_CMD_MWI;                 // see RL5
               txn_next.len_dw = mwi_len;
            end
            else
            begin
               txn_next.cmd = PBCS_CMD_MW;                  // see RL10
               if (line_ok && (rem_reg > bnd_len))
               begin
                  txn_next.len_dw = bnd_len;                // only up to the next line boundary
               end
            end
            tleft_next = txn_next.len_dw;
            be_next = ((txn_next.cmd == PBCS_CMD_MWI) || (rem_reg != 16'h0001)) ? PBCS_BE_ALL : last_be_reg;
            state_next = PBCS_ISSUE;
         end
         PBCS_ISSUE:
         begin
            if (TXN_READY)
            begin
               state_next = PBCS_DATA;
            end
         end
         PBCS_DATA:
         begin
            if (DPHASE_DONE)
            begin
               addr_next = addr_reg + 62'h1;
               rem_next = rem_reg - 16'h0001;
               tleft_next = tleft_reg - 16'h0001;
               // all lanes for invalidate, final lanes on the last dword
               be_next = ((txn_reg.cmd == PBCS_CMD_MWI) || (rem_next != 16'h0001)) ? PBCS_BE_ALL : last_be_reg; // see RL12
               if (DPHASE_LAST)
               begin
                  if (rem_reg == 16'h0001)
                  begin
                     state_next = PBCS_IDLE;
                     done_next = 1'b1;
                  end
                  else
                  begin
                     state_next = PBCS_PLAN;
                  end
               end
            end
         end
         default:
         begin
            state_next = PBCS_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge REF_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_reg <= PBCS_IDLE;
         write_reg <= 1'b0;
         addr_reg <= PBCS_ADDR_RST;
         rem_reg <= PBCS_LEN_RST;
         tleft_reg <= PBCS_LEN_RST;
         last_be_reg <= PBCS_BE_ALL;
         be_reg <= PBCS_BE_ALL;
         done_reg <= 1'b0;
         txn_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         write_reg <= write_next;
         addr_reg <= addr_next;
         rem_reg <= rem_next;
         tleft_reg <= tleft_next;
         last_be_reg <= last_be_next;
         be_reg <= be_next;
         done_reg <= done_next;
         txn_reg <= txn_next;
      end
   end

   // data outputs from registers
   always_comb
   begin
      TXN = txn_reg;
      BYTE_EN = be_reg;
      XFER_DONE = done_reg;
      BURST_ORDER = txn_reg.addr[1:0];
   end

   // checks on the chosen commands
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!NRST);

   mwi_lanes_a: // see RL12
   assert property ((state_reg == PBCS_DATA) && (txn_reg.cmd == PBCS_CMD_MWI) |-> BYTE_EN == PBCS_BE_ALL)
      else $error("invalidate data phase without all byte enables");

   mwi_aligned_a: // see RL7
   assert property (TXN_VALID && (TXN.cmd == PBCS_CMD_MWI) |-> aligned && (TXN.len_dw[2:0] == 3'h0))
      else $error("invalidate burst not on a line boundary");

   mwi_line_size_a: // see RL6
   assert property (TXN_VALID && (TXN.cmd == PBCS_CMD_MWI)
      |-> (CACHE_LINE_SIZE == PBCS_CLS_8) || (CACHE_LINE_SIZE == PBCS_CLS_16))
      else $error("invalidate with unsupported line size");

   mwi_fifo_enable_a: // see RL8 see RL9
   assert property ($rose(TXN_VALID) && (TXN.cmd == PBCS_CMD_MWI)
      |-> $past(MWI_ENABLE) && ($past(RX_FIFO_DW) >= {3'h0, $past(line_dw)}))
      else $error("invalidate chosen without data or enable");

   dac_high_a: // see RL15
   assert property (TXN_VALID |-> TXN.dac == (TXN.addr[63:32] != 32'h0))
      else $error("dual address cycle flag wrong");

   linear_order_a: // see RL14
   assert property (TXN_VALID |-> BURST_ORDER == PBCS_LINEAR_ORDER)
      else $error("burst ordering not linear");

   mrl_to_bound_a: // see RL2
   assert property (TXN_VALID && (TXN.cmd == PBCS_CMD_MRL) |-> !aligned && (TXN.len_dw == bnd_len))
      else $error("read line does not end at the boundary");

   mrm_whole_a: // see RL1
   assert property (TXN_VALID && (TXN.cmd == PBCS_CMD_MRM) |-> aligned && (TXN.len_dw == full_dw))
      else $error("read multiple not over whole lines");

   mr_short_a: // see RL3
   assert property (TXN_VALID && (TXN.cmd == PBCS_CMD_MR) && line_ok && !aligned |-> TXN.len_dw < bnd_len)
      else $error("plain read reaches a line boundary");

   tx_short_stop_a: // see RL4
   assert property ((state_reg == PBCS_DATA) && (txn_reg.cmd == PBCS_CMD_MRM) && at_end && TX_FIFO_NEAR_FULL
      |-> DPHASE_LAST)
      else $error("read multiple ran past a boundary while tx short");

   mwi_cross_a: // see RL11 see RL13
   assert property (DPHASE_DONE && (state_reg == PBCS_DATA) && (txn_reg.cmd == PBCS_CMD_MWI) && at_end
      && !DPHASE_LAST |-> MWI_ENABLE && (RX_FIFO_DW > line_lvl))
      else $error("invalidate crossed into a line it cannot fill");

   txn_hold_a: // see RL17
   assert property (TXN_VALID && !TXN_READY |=> TXN_VALID && $stable(TXN))
      else $error("transaction changed while offered");
endmodule : pbcs_top
`default_nettype wire

// >>> verif/pbcs_tgt_model.sv
// bus engine and memory target model facing the command selector
`timescale 1ns/10ps
`default_nettype none
module pbcs_tgt_model
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // transaction hand-off
   input wire logic txn_valid,
   input wire pbcs_pkg::pbcs_txn_t txn,
   output logic txn_ready,
   // data phases
   output logic dphase_done,
   input wire logic dphase_last,
   input wire logic [3:0] byte_en,
   input wire logic [1:0] burst_order,
   // wait states per step
   input wire logic [1:0] slow
);
   import pbcs_pkg::*;
   pbcs_txn_t log_q[$];
   logic [15:0] ph_q[$];
   int bad_cnt = 0;
   logic [15:0] ph;
   logic [3:0] cmd;
   logic [3:0] be_seen;
   logic fin;
   // take a transaction, then run phases until the last one
   initial
   begin
      txn_ready = 1'b0;
      dphase_done = 1'b0;
      forever
      begin
         @(posedge clk);
         if (nrst === 1'b1 && txn_valid === 1'b1)
         begin
            repeat (slow) @(posedge clk);
            txn_ready <= 1'b1;
            @(posedge clk);
            txn_ready <= 1'b0;
            log_q.push_back(txn);
            cmd = txn.cmd;
            ph = 16'h0000;
            fin = 1'b0;
            while (!fin)
            begin
               repeat (slow) @(posedge clk);
               dphase_done <= 1'b1;
               @(posedge clk);
               ph = ph + 16'h0001;
               if ((cmd === PBCS_CMD_MWI && byte_en !== PBCS_BE_ALL) || burst_order !== PBCS_LINEAR_ORDER)
                  bad_cnt++;
               be_seen = byte_en;
               fin = (dphase_last === 1'b1);
               if (fin || slow != 2'h0)
                  dphase_done <= 1'b0;
            end
            ph_q.push_back(ph);
         end
      end
   end
endmodule : pbcs_tgt_model
`default_nettype wire

// >>> verif/pbcs_top_tb.sv
// self-checking bench of the bus-master command selector
`timescale 1ns/10ps
`default_nettype none
module pbcs_top_tb;
   import pbcs_pkg::*;
   logic ref_clk, nrst, req_valid, req_ready, xfer_done, mwi_en, tx_nf, txn_valid, txn_ready;
   logic dph_done, dph_last;
   logic [7:0] cls, rx_dw;
   logic [3:0] be;
   logic [1:0] order, slow;
   pbcs_req_t req;
   pbcs_txn_t txn;
   int err_total = 0;
   int n_checks = 0;
   logic [3:0] e_cmd[$];
   logic [61:0] e_adr[$];
   logic [15:0] e_ph[$];

   pbcs_top i_pbcs_top (.REF_CLK(ref_clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ(req),
      .REQ_READY(req_ready), .XFER_DONE(xfer_done), .CACHE_LINE_SIZE(cls), .MWI_ENABLE(mwi_en),
      .TX_FIFO_NEAR_FULL(tx_nf), .RX_FIFO_DW(rx_dw), .TXN_VALID(txn_valid), .TXN(txn),
      .TXN_READY(txn_ready), .DPHASE_DONE(dph_done), .DPHASE_LAST(dph_last), .BYTE_EN(be),
      .BURST_ORDER(order));
   pbcs_tgt_model i_pbcs_tgt_model (.clk(ref_clk), .nrst(nrst), .txn_valid(txn_valid), .txn(txn),
      .txn_ready(txn_ready), .dphase_done(dph_done), .dphase_last(dph_last), .byte_en(be),
      .burst_order(order), .slow(slow));

   // clock at 4 ns
   always #2 ref_clk = ~ref_clk;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic add(input logic [3:0] c, input logic [61:0] a, input logic [15:0] p);
      e_cmd.push_back(c);
      e_adr.push_back(a);
      e_ph.push_back(p);
   endtask : add

   // one move, then compare every transaction against the expected list
   task automatic move(input logic w, input logic [61:0] a, input logic [15:0] n, input logic [3:0] lb,
      input int drop);
      int base;
      int k;
      pbcs_txn_t t;
      base = i_pbcs_tgt_model.log_q.size();
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{write: w, addr_dw: a, len_dw: n, last_be: lb};
      do @(posedge ref_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      k = 0;
      do
      begin
         @(posedge ref_clk);
         k++;
         if (k == drop)
            mwi_en <= 1'b0;
      end
      while (xfer_done !== 1'b1 && k < 3000);
      check(64'(k < 3000), 64'h1);
      check(64'(i_pbcs_tgt_model.log_q.size() - base), 64'(e_cmd.size()));
      foreach (e_cmd[j])
      begin
         t = i_pbcs_tgt_model.log_q[base + j];
         check(64'(t.cmd), 64'(e_cmd[j]));
         check(t.addr, {e_adr[j], 2'b00});
         check(64'(t.dac), 64'(e_adr[j][61:30] != 32'h0));
         check(64'(i_pbcs_tgt_model.ph_q[base + j]), 64'(e_ph[j]));
      end
      e_cmd.delete();
      e_adr.delete();
      e_ph.delete();
   endtask : move

   task automatic t_read_split;
      add(PBCS_CMD_MRL, 62'd65, 16'd15);
      add(PBCS_CMD_MRM, 62'd80, 16'd16);
      add(PBCS_CMD_MR, 62'd96, 16'd9);
      move(1'b0, 62'd65, 16'd40, 4'hf, 0);
      move(1'b0, 62'd0, 16'd0, 4'hf, 0);
      cls <= 8'h0c;
      add(PBCS_CMD_MR, 62'd65, 16'd40);
      move(1'b0, 62'd65, 16'd40, 4'hf, 0);
      cls <= PBCS_CLS_16;
      $display("read split done");
   endtask : t_read_split

   task automatic t_read_high;
      tx_nf <= 1'b1;
      add(PBCS_CMD_MRM, 62'h4000_0000, 16'd16);
      add(PBCS_CMD_MRM, 62'h4000_0010, 16'd16);
      add(PBCS_CMD_MRM, 62'h4000_0020, 16'd16);
      move(1'b0, 62'h4000_0000, 16'd48, 4'hf, 0);
      tx_nf <= 1'b0;
      $display("read high done");
   endtask : t_read_high

   task automatic t_write_line;
      cls <= PBCS_CLS_8;
      slow <= 2'h2;
      add(PBCS_CMD_MW, 62'd26, 16'd6);
      add(PBCS_CMD_MWI, 62'd32, 16'd24);
      move(1'b1, 62'd26, 16'd30, 4'hf, 0);
      slow <= 2'h0;
      cls <= PBCS_CLS_16;
      add(PBCS_CMD_MWI, 62'd64, 16'd16);
      move(1'b1, 62'd64, 16'd16, 4'hf, 0);
      $display("write line done");
   endtask : t_write_line

   task automatic t_write_fail;
      cls <= 8'h0c;
      add(PBCS_CMD_MW, 62'd64, 16'd16);
      move(1'b1, 62'd64, 16'd16, 4'hf, 0);
      cls <= PBCS_CLS_8;
      mwi_en <= 1'b0;
      add(PBCS_CMD_MW, 62'd64, 16'd8);
      add(PBCS_CMD_MW, 62'd72, 16'd8);
      move(1'b1, 62'd64, 16'd16, 4'hf, 0);
      mwi_en <= 1'b1;
      rx_dw <= 8'd7;
      add(PBCS_CMD_MW, 62'd64, 16'd8);
      add(PBCS_CMD_MW, 62'd72, 16'd8);
      move(1'b1, 62'd64, 16'd16, 4'hf, 0);
      rx_dw <= 8'd8;
      add(PBCS_CMD_MWI, 62'd64, 16'd8);
      add(PBCS_CMD_MWI, 62'd72, 16'd8);
      move(1'b1, 62'd64, 16'd16, 4'hf, 0);
      rx_dw <= 8'd64;
      add(PBCS_CMD_MWI, 62'd64, 16'd8);
      add(PBCS_CMD_MW, 62'd72, 16'd8);
      move(1'b1, 62'd64, 16'd16, 4'h3, 0);
      check(64'(i_pbcs_tgt_model.be_seen), 64'h3);
      $display("write fail done");
   endtask : t_write_fail

   task automatic t_write_drop;
      add(PBCS_CMD_MWI, 62'd0, 16'd8);
      add(PBCS_CMD_MW, 62'd8, 16'd8);
      add(PBCS_CMD_MW, 62'd16, 16'd8);
      move(1'b1, 62'd0, 16'd24, 4'hf, 6);
      mwi_en <= 1'b1;
      $display("write drop done");
   endtask : t_write_drop

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   // reset, then the scenarios in turn
   initial
   begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      cls = PBCS_CLS_16;
      mwi_en = 1'b1;
      tx_nf = 1'b0;
      rx_dw = 8'd64;
      slow = 2'h0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      t_read_split();
      t_read_high();
      t_write_line();
      t_write_fail();
      t_write_drop();
      check(64'(i_pbcs_tgt_model.bad_cnt), 64'h0);
      stop_test();
   end

   // watchdog well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end
endmodule : pbcs_top_tb
`default_nettype wire
